/* File: inc/dmap_pkg.sv */
// package: constants for the local data memory decoder and protect logic
// assumes: 16-bit word addresses, one clock domain
package dmap_pkg;

  localparam int ADDR_W = 16;
  localparam int DATA_W = 16;

  // data page 0 and dual-access blocks
  localparam logic [15:0] MMR_LO    = 16'h0000;
  localparam logic [15:0] MMR_HI    = 16'h004F;
  localparam logic [15:0] MIO_LO    = 16'h0050;
  localparam logic [15:0] MIO_HI    = 16'h005F;
  localparam logic [15:0] B2_LO     = 16'h0060;
  localparam logic [15:0] B2_HI     = 16'h007F;
  localparam logic [15:0] B0_LO     = 16'h0100;
  localparam logic [15:0] B0_HI     = 16'h02FF;
  localparam logic [15:0] B1_LO     = 16'h0300;
  localparam logic [15:0] B1_HI     = 16'h04FF;
  localparam logic [15:0] SINGLE_ACCESS_RAM_LO  = 16'h0800;
  localparam logic [15:0] RSV_TOP   = 16'h0800;
  localparam int          DUAL_ACCESS_RAM_WORDS = 1056;

  // default single-access RAM size (9K words)
  localparam int          SINGLE_ACCESS_RAM_WORDS_DEF = 9216;

  // reset values of the mapping bits
  localparam logic        B0_PROG_RST   = 1'b0;
  localparam logic        SINGLE_RAM_DATA_OVERLAY_RST      = 1'b0;

  // decode targets
  typedef enum logic [2:0] {
    TGT_MMR,
    TGT_MIO,
    TGT_B2,
    TGT_B0,
    TGT_B1,
    TGT_SINGLE_ACCESS_RAM,
    TGT_RSV,
    TGT_EXT
  } target_t;

endpackage

/* File: verilog/data_region_decode.sv */
// data region decoder: classifies one local data address
// assumes: mapping bits already registered by the caller
`timescale 1ns/10ps
module data_region_decode
  import dmap_pkg::*;
#(
  parameter int          SINGLE_ACCESS_RAM_WORDS = SINGLE_ACCESS_RAM_WORDS_DEF,
  parameter bit          HAS_SINGLE_ACCESS_RAM   = 1'b1
) (
  // address and mapping
  input  wire logic [15:0] addr,
  input  wire logic        b0_prog,
  input  wire logic        single_ram_data_overlay_eff,
  // result
  output target_t          target
);

  localparam logic [16:0] SINGLE_ACCESS_RAM_END =
    17'(int'(SINGLE_ACCESS_RAM_LO) + SINGLE_ACCESS_RAM_WORDS);

  always_comb begin
    if (addr <= MMR_HI)
      target = TGT_MMR;
    else if (addr <= MIO_HI)
      target = TGT_MIO;
    else if (addr <= B2_HI)
      target = TGT_B2;
    else if (addr >= B0_LO && addr <= B0_HI)
      target = b0_prog ? TGT_RSV : TGT_B0;
    else if (addr >= B1_LO && addr <= B1_HI)
      target = TGT_B1;
    else if (addr < RSV_TOP)
      target = TGT_RSV;
    else if (HAS_SINGLE_ACCESS_RAM && single_ram_data_overlay_eff && {1'b0, addr} < SINGLE_ACCESS_RAM_END)
      target = TGT_SINGLE_ACCESS_RAM;
    else
      target = TGT_EXT;
  end

endmodule // data_region_decode

/* File: verilog/data_memory_map.sv */
// data memory map and program protect: routes data accesses, guards
// on-chip program memory when the mask protect option is set
// assumes: core presents one access per cycle with fetch-source tags;
// all inputs come from logic on clk
//
// Behaviour
// - protected: off-chip fetched op to on-chip program gets invalid data.
// - protected: op fetched from B0 cannot touch on-chip program memory.
// - protected: off-chip MAC coefficients not taken from on-chip program.
// - protected: single-access RAM never mapped to data; its program range stays on-chip.
// - protected: external DMA requests refused.
// - protected: emulator blocked from on-chip program memory.
// - protected: program range of single-access RAM not sent off-chip.
// - decode 64K locations of 16-bit words.
// - mapped blocks decoded on-chip, everything else from 0800 up external.
// - after reset all 1056 dual-access words are in data space.
// - B0 program select moves B0; 0100-02FF becomes reserved.
// - overlay bit maps single-access RAM at 0800, else off-chip.
// - unmapped 0000-07FF is reserved, never external.
// - 0000-004F registers, 0050-005F I/O ports, always.
// - without single-access RAM overlay is ignored, 0800 up external.
// - B2 scratch-pad reachable by any data addressing mode.
`timescale 1ns/10ps
module data_memory_map
  import dmap_pkg::*;
#(
  parameter int          SINGLE_ACCESS_RAM_WORDS  = SINGLE_ACCESS_RAM_WORDS_DEF,
  parameter bit          HAS_SINGLE_ACCESS_RAM    = 1'b1,
  parameter bit          PROTECT_MASK = 1'b0,
  parameter logic [15:0] PROG_ROM_LO  = 16'h0000,
  parameter logic [15:0] PROG_ROM_HI  = 16'h07FF,
  parameter logic [15:0] PROG_SA_LO   = 16'h0800,
  parameter logic [15:0] PROG_SA_HI   = 16'h2BFF,
  parameter logic [15:0] INVALID_WORD = 16'h0000
) (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              sys_rst,
  // mapping bits from the status registers
  input  wire logic              block_b0_program_select,
  input  wire logic              single_ram_data_overlay,
  // data access request
  input  wire logic              dreq,
  input  wire logic [15:0]       daddr,
  // program-space operand access request
  input  wire logic              preq,
  input  wire logic [15:0]       paddr,
  input  wire logic              pmac,
  // source of the instruction issuing the access
  input  wire logic              fetch_offchip,
  input  wire logic              fetch_from_b0,
  // program read data from on-chip memory
  input  wire logic [15:0]       prog_rdata_in,
  // emulation and external DMA requests
  input  wire logic              emu_req,
  input  wire logic [15:0]       emu_addr,
  input  wire logic              dma_req,
  // data decode results
  output target_t                dtarget,
  output logic                   dext_start,
  output logic                   dvalid,
  // program operand results
  output logic                   pext_start,
  output logic                   pblock,
  output logic [15:0]            prog_rdata,
  // emulation and DMA answers
  output logic                   emu_grant,
  output logic                   dma_grant,
  // status
  output logic                   protect_on,
  output logic                   single_access_ram_data_mapped
);

  // ************************************************************
  // mapping state
  // ************************************************************
  logic    b0_prog_reg, b0_prog_next;
  logic    single_ram_data_overlay_reg, single_ram_data_overlay_next;
  logic    single_ram_data_overlay_eff;
  target_t dec_target;

  always_comb begin
    b0_prog_next = block_b0_program_select;
    single_ram_data_overlay_next    = single_ram_data_overlay;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      b0_prog_reg <= B0_PROG_RST;
      single_ram_data_overlay_reg    <= SINGLE_RAM_DATA_OVERLAY_RST;
    end else begin
      b0_prog_reg <= b0_prog_next;
      single_ram_data_overlay_reg    <= single_ram_data_overlay_next;
    end
  end

  // the mapping bits reach the decoder one cycle after they are sampled,
  // so a change of map never splits one access between two decodes
  // protected parts never overlay; RAM-less parts ignore the bit
  assign single_ram_data_overlay_eff = single_ram_data_overlay_reg & ~PROTECT_MASK & HAS_SINGLE_ACCESS_RAM;

  data_region_decode #(
    .SINGLE_ACCESS_RAM_WORDS (SINGLE_ACCESS_RAM_WORDS),
    .HAS_SINGLE_ACCESS_RAM   (HAS_SINGLE_ACCESS_RAM)
  ) u_dec (
    .addr     (daddr),
    .b0_prog  (b0_prog_reg),
    .single_ram_data_overlay_eff (single_ram_data_overlay_eff),
    .target   (dec_target)
  );

  // ************************************************************
  // program-space protection checks
  // ************************************************************
  logic p_in_rom, p_in_sa, p_onchip;
  logic e_in_rom, e_in_sa, e_onchip;
  logic src_offchip, src_b0, mac_offchip;
  logic p_viol, p_ext;

  // address windows of on-chip program memory, operand and emulator side
  always_comb begin
    p_in_rom = paddr >= PROG_ROM_LO && paddr <= PROG_ROM_HI;
    p_in_sa  = paddr >= PROG_SA_LO && paddr <= PROG_SA_HI;
    p_onchip = p_in_rom | p_in_sa;
    e_in_rom = emu_addr >= PROG_ROM_LO && emu_addr <= PROG_ROM_HI;
    e_in_sa  = emu_addr >= PROG_SA_LO && emu_addr <= PROG_SA_HI;
    e_onchip = e_in_rom | e_in_sa;
  end

  // tracked instruction sources, only counted on a protected part
  always_comb begin
    src_offchip = PROTECT_MASK && fetch_offchip;
    src_b0      = PROTECT_MASK && fetch_from_b0;
    mac_offchip = PROTECT_MASK && fetch_offchip && pmac;
  end

  always_comb begin
    // a tracked source touching on-chip program memory is refused
    p_viol = preq && p_onchip && (src_offchip || src_b0 || mac_offchip);
    // protected SA range stays internal; ROM range is never external
    p_ext  = preq && !p_in_rom && !(PROTECT_MASK && p_in_sa);
  end

  // ************************************************************
  // output registers
  // ************************************************************
  target_t     dtarget_next;
  logic        dext_next, dvalid_next, pext_next, pblock_next;
  logic [15:0] prdata_next;
  logic        emu_next, dma_next, sa_map_next;

  always_comb begin
    dtarget_next = dec_target;
    dvalid_next  = dreq;
    dext_next    = dreq && dec_target == TGT_EXT;
    pext_next    = p_ext;
    pblock_next  = p_viol;
    prdata_next  = p_viol ? INVALID_WORD : prog_rdata_in;
    emu_next     = emu_req && !(PROTECT_MASK && e_onchip);
    dma_next     = dma_req && !PROTECT_MASK;
    sa_map_next  = single_ram_data_overlay_eff;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      dtarget           <= TGT_MMR;
      dext_start        <= 1'b0;
      dvalid            <= 1'b0;
      pext_start        <= 1'b0;
      pblock            <= 1'b0;
      prog_rdata        <= 16'h0000;
      emu_grant         <= 1'b0;
      dma_grant         <= 1'b0;
      protect_on        <= 1'b0;
      single_access_ram_data_mapped <= 1'b0;
    end else begin
      dtarget           <= dtarget_next;
      dext_start        <= dext_next;
      dvalid            <= dvalid_next;
      pext_start        <= pext_next;
      pblock            <= pblock_next;
      prog_rdata        <= prdata_next;
      emu_grant         <= emu_next;
      dma_grant         <= dma_next;
      protect_on        <= PROTECT_MASK;
      single_access_ram_data_mapped <= sa_map_next;
    end
  end

endmodule // data_memory_map

/* File: tb/dmap_monitor.sv */
// checker: data decode relations seen at the top ports
// assumes: bound into data_memory_map, single clock domain
`timescale 1ns/10ps
module dmap_monitor
  import dmap_pkg::*;
#(parameter int SINGLE_ACCESS_RAM_WORDS = SINGLE_ACCESS_RAM_WORDS_DEF) (
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic        block_b0_program_select,
  input wire logic        single_ram_data_overlay,
  input wire logic [15:0] daddr,
  input wire target_t     dtarget,
  input wire logic        dext_start,
  input wire logic        dvalid,
  input wire logic        dma_grant,
  input wire logic        protect_on,
  input wire logic        single_access_ram_data_mapped
);
  localparam int TOP = SINGLE_ACCESS_RAM_LO + SINGLE_ACCESS_RAM_WORDS;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence s_b0; daddr inside {[B0_LO:B0_HI]}; endsequence
  sequence s_sa; daddr >= SINGLE_ACCESS_RAM_LO && daddr < TOP; endsequence
  a_regs_decode: assert property (daddr <= MMR_HI |=>
    dtarget == TGT_MMR) else $error("register range decode");
  a_pad_decode: assert property (daddr inside {[B2_LO:B2_HI]} |=>
    dtarget == TGT_B2) else $error("scratch pad decode");
  a_b0_data: assert property (s_b0 ##0
    !$past(block_b0_program_select) |=> dtarget == TGT_B0)
    else $error("block b0 not in data");
  a_b0_moved: assert property (s_b0 ##0
    $past(block_b0_program_select) |=> dtarget == TGT_RSV)
    else $error("block b0 range not reserved");
  a_low_onchip: assert property (daddr < RSV_TOP |=>
    dtarget != TGT_EXT) else $error("low range went external");
  a_sa_overlay: assert property (s_sa ##0
    ($past(single_ram_data_overlay) && !protect_on) |=> dtarget == TGT_SINGLE_ACCESS_RAM)
    else $error("overlay not mapped");
  a_top_ext: assert property (daddr >= TOP |=>
    dtarget == TGT_EXT) else $error("above overlay not external");
  a_ext_start: assert property (1'b1 |-> dext_start ==
    (dvalid && dtarget == TGT_EXT)) else $error("external start wrong");
  a_prot_nomap: assert property (protect_on |->
    !single_access_ram_data_mapped) else $error("overlay mapped while protected");
  a_prot_nodma: assert property (protect_on |->
    !dma_grant) else $error("dma granted while protected");
endmodule // dmap_monitor

bind data_memory_map dmap_monitor #(.SINGLE_ACCESS_RAM_WORDS(SINGLE_ACCESS_RAM_WORDS)) mon_u (
  .clk(clk), .sys_rst(sys_rst), .daddr(daddr),
  .block_b0_program_select(block_b0_program_select),
  .single_ram_data_overlay(single_ram_data_overlay),
  .dtarget(dtarget), .dext_start(dext_start), .dvalid(dvalid),
  .dma_grant(dma_grant), .protect_on(protect_on),
  .single_access_ram_data_mapped(single_access_ram_data_mapped));

/* File: tb/prog_mem_model.sv */
// partner: on-chip program memory answering the operand bus
// assumes: read data returned in the cycle of the address
`timescale 1ns/10ps
module prog_mem_model (
  input  wire logic [15:0] paddr,
  output logic      [15:0] rdata
);
  // contents are a fixed scramble of the address
  assign rdata = {paddr[7:0], ~paddr[15:8]};
endmodule // prog_mem_model

/* File: tb/tb_top.sv */
// testbench: boundary and random data addresses through the map
// assumes: 1K words of single-access RAM, one plain and one protected part
`timescale 1ns/10ps
module tb_top;
  import dmap_pkg::*;
  localparam int SW = 1024;
  localparam int N  = 3000;
  localparam logic [15:0] P_ROM_HI  = 16'h07FF;
  localparam logic [15:0] P_SA_LO   = 16'h0800;
  localparam logic [15:0] P_SA_HI   = 16'h0BFF;
  localparam logic [15:0] P_INVALID = 16'h0000;
  logic [15:0] prog_rdata_p;
  logic [6:0]  sp;
  logic        pxu, pxp;
  target_t     dtarget_p;
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic [5:0]  ctl = 6'h00;
  logic [1:0]  map = 2'h0;
  logic [15:0] daddr = 16'h0000;
  logic [15:0] paddr = 16'h0000;
  logic [15:0] prd, prog_rdata;
  logic [6:0]  st, es;
  target_t     dtarget;
  logic [15:0] ad[N], pa[N];
  logic [5:0]  rq[N];
  logic [1:0]  mb[N];
  logic [31:0] seed = 32'h390DEC84;
  int          err_count = 0;
  int          samples_checked = 0;
  logic [15:0] cor[12] = '{16'h004F, 16'h0060, 16'h007F, 16'h0080,
    16'h0100, 16'h02FF, 16'h0300, 16'h07FF, 16'h0800, 16'h0BFF,
    16'h0C00, 16'hFFFF};
  always #20 clk = ~clk;
  prog_mem_model mem_u (.paddr(paddr), .rdata(prd));
  data_memory_map #(.SINGLE_ACCESS_RAM_WORDS(SW), .PROTECT_MASK(1'b1),
    .PROG_ROM_HI(P_ROM_HI), .PROG_SA_LO(P_SA_LO), .PROG_SA_HI(P_SA_HI),
    .INVALID_WORD(P_INVALID)) dut_u_prot (
    .clk(clk), .sys_rst(sys_rst),
    .block_b0_program_select(map[1]), .single_ram_data_overlay(map[0]),
    .dreq(ctl[5]), .daddr(daddr), .preq(ctl[4]), .paddr(paddr),
    .pmac(ctl[3]), .fetch_offchip(ctl[2]), .fetch_from_b0(ctl[1]),
    .prog_rdata_in(prd), .emu_req(ctl[0]), .emu_addr(~paddr),
    .dma_req(ctl[5] ^ ctl[4]), .dtarget(dtarget_p), .dext_start(sp[0]),
    .dvalid(sp[1]), .pext_start(pxp), .pblock(sp[2]),
    .prog_rdata(prog_rdata_p), .emu_grant(sp[3]), .dma_grant(sp[4]),
    .protect_on(sp[5]), .single_access_ram_data_mapped(sp[6]));
  data_memory_map #(.SINGLE_ACCESS_RAM_WORDS(SW), .PROG_ROM_HI(P_ROM_HI),
    .PROG_SA_LO(P_SA_LO), .PROG_SA_HI(P_SA_HI)) dut_u (
    .clk(clk), .sys_rst(sys_rst),
    .block_b0_program_select(map[1]), .single_ram_data_overlay(map[0]),
    .dreq(ctl[5]), .daddr(daddr), .preq(ctl[4]), .paddr(paddr),
    .pmac(ctl[3]), .fetch_offchip(ctl[2]), .fetch_from_b0(ctl[1]),
    .prog_rdata_in(prd), .emu_req(ctl[0]), .emu_addr(~paddr),
    .dma_req(ctl[5] ^ ctl[4]), .dtarget(dtarget), .dext_start(st[0]),
    .dvalid(st[1]), .pext_start(pxu), .pblock(st[2]),
    .prog_rdata(prog_rdata), .emu_grant(st[3]), .dma_grant(st[4]),
    .protect_on(st[5]), .single_access_ram_data_mapped(st[6]));
  function automatic logic [31:0] xs(logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    return s ^ (s << 5);
  endfunction
  function automatic target_t exp_t(logic [15:0] a, logic [1:0] m);
    if (a <= MMR_HI) return TGT_MMR;
    if (a <= MIO_HI) return TGT_MIO;
    if (a <= B2_HI) return TGT_B2;
    if (a >= B0_LO && a <= B0_HI) return m[1] ? TGT_RSV : TGT_B0;
    if (a >= B1_LO && a <= B1_HI) return TGT_B1;
    if (a < RSV_TOP) return TGT_RSV;
    if (m[0] && a < SINGLE_ACCESS_RAM_LO + SW) return TGT_SINGLE_ACCESS_RAM;
    return TGT_EXT;
  endfunction
  function automatic bit onp(logic [15:0] a);
    return a <= P_ROM_HI || (a >= P_SA_LO && a <= P_SA_HI);
  endfunction
  // {program operand external, protection violation}
  function automatic logic [1:0] exp_p(logic [15:0] a, logic [5:0] r,
                                       bit pm);
    return {r[4] && a > P_ROM_HI && !(pm && onp(a)),
            pm && r[4] && onp(a) && (r[2] || r[1])};
  endfunction
  task automatic chk(string n, logic [15:0] e, logic [15:0] s);
    samples_checked++;
    if (e !== s) begin
      $display("wrong value %s expected %h seen %h", n, e, s);
      err_count++;
    end
  endtask
  task automatic results;
    if (err_count == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #(40 * (N + 100));
    err_count++;
    results;
  end
  initial begin
    target_t e, f;
    logic [1:0] eu, ep;
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    for (int i = 0; i < N; i++) begin
      @(posedge clk);
      seed = xs(seed);
      ad[i] = (i % 2 == 0) ? cor[(i / 2) % 12] : seed[15:0];
      pa[i] = seed[31:16];
      seed = xs(seed);
      rq[i] = seed[5:0];
      mb[i] = (i % 16 == 0) ? seed[9:8] : mb[i - 1];
      daddr <= ad[i];
      paddr <= pa[i];
      ctl <= rq[i];
      map <= mb[i];
      @(negedge clk);
      if (i >= 2) begin
        e = exp_t(ad[i - 1], mb[i - 2]);
        es = {mb[i - 2][0], 1'b0, rq[i - 1][5] ^ rq[i - 1][4],
          rq[i - 1][0], 1'b0, rq[i - 1][5], rq[i - 1][5] && e == TGT_EXT};
        chk("dtarget", 16'(e), 16'(dtarget));
        chk("status", {9'h000, es}, {9'h000, st});
        chk("prog_rdata", {pa[i - 1][7:0], ~pa[i - 1][15:8]},
          prog_rdata);
        f = exp_t(ad[i - 1], mb[i - 2] & 2'b10);
        eu = exp_p(pa[i - 1], rq[i - 1], 1'b0);
        ep = exp_p(pa[i - 1], rq[i - 1], 1'b1);
        es = {1'b0, 1'b1, 1'b0, rq[i - 1][0] && !onp(~pa[i - 1]), ep[0],
          rq[i - 1][5], rq[i - 1][5] && f == TGT_EXT};
        chk("pext_start", 16'(eu[1]), 16'(pxu));
        chk("dtarget_p", 16'(f), 16'(dtarget_p));
        chk("status_p", {9'h000, es}, {9'h000, sp});
        chk("pext_p", 16'(ep[1]), 16'(pxp));
        chk("prog_rdata_p", ep[0] ? P_INVALID : {pa[i - 1][7:0],
          ~pa[i - 1][15:8]}, prog_rdata_p);
      end
    end
    results;
  end
endmodule // tb_top
